// ---- cao_angle.sv ----
// Commutation angle selection, offset and automatic offset adjustment
//
// Function
// - Feedback angle chosen from resolver, encoder or fixed zero.
// - Zero source holds the feedback angle at zero regardless of sensors.
// - Resolver source uses resolver position, 16 bits per revolution.
// - Encoder source uses encoder angle, 16 bits per revolution.
// - Stored programmable offset added between feedback and phase angle.
// - Current loop gains halved while the adjustment runs.
// - Adjustment first commands one eighth of maximum torque to loosen rotor.
// - Then quarter torque at fixed electrical angle; offset taken from position.
// - Armed start begins the sequence when the drive is enabled with torque mode set.
// - Completion indicator goes to zero when the sequence finishes.
// - Offset saved automatically with storage enabled, else by operator save.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/1ns

module cao_angle #(
  parameter logic [31:0] TICK_CYCLES = cao_pkg::TICK_CYCLES,
  parameter logic [15:0] LOOSEN_MS = 16'(cao_pkg::LOOSEN_MS),
  parameter logic [15:0] ALIGN_MS = 16'(cao_pkg::ALIGN_MS)
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cao_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cao_pkg::cao_fb_s fb,
  output cao_pkg::cao_drv_s drv
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic mapped(input logic [cao_pkg::ADDR_W-1:0] a);
    logic hit;
    hit = 1'b0;
    unique case (a)
      cao_pkg::ADDR_CTRL,
      cao_pkg::ADDR_OFFSET,
      cao_pkg::ADDR_STATUS,
      cao_pkg::ADDR_ANGLE,
      cao_pkg::ADDR_GAIN,
      cao_pkg::ADDR_TMAX:
        hit = 1'b1;
      default:
        hit = 1'b0;
    endcase
    return hit;
  endfunction

  function automatic logic [15:0] frac_torque(input logic [15:0] tmax, input int sh);
    return tmax >> sh;
  endfunction

  function automatic logic span_end(input logic [15:0] ms, input logic [15:0] len);
    return ms == len - 16'h0001;
  endfunction

  function automatic logic [15:0] ms_step(input logic [15:0] ms);
    return ms + 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  cao_pkg::cao_state_s s_r;
  cao_pkg::cao_state_s s_nxt;
  logic access;
  logic wr;
  logic tick;
  logic [15:0] sel_angle;

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  assign access = psel & penable;
  assign wr = access & pwrite & mapped(paddr);
  assign pready = access;
  assign pslverr = access & ~mapped(paddr);
  assign prdata = s_r.rdata;

  // ----------------------------------------------------------------
  // Outputs and millisecond tick
  // ----------------------------------------------------------------
  assign drv = s_r.drv;
  assign tick = (s_r.div == TICK_CYCLES - 32'h00000001);

  // ----------------------------------------------------------------
  // Feedback source selection
  // ----------------------------------------------------------------
  always_comb
  begin
    sel_angle = 16'h0000;
    unique case (s_r.src)
      cao_pkg::SRC_RESOLVER:
        sel_angle = fb.resolver_pos;
      cao_pkg::SRC_ENCODER:
        sel_angle = fb.encoder_pos;
      default:
        sel_angle = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.drv.nv_save = 1'b0;
    s_nxt.drv.param_save = 1'b0;

    // ----------------------------------------------------------------
    // Read data latched in the setup cycle
    // ----------------------------------------------------------------
    if (psel && !penable)
    begin
      s_nxt.rdata = 32'h00000000;
      unique case (paddr)
        cao_pkg::ADDR_CTRL:
        begin
          s_nxt.rdata[cao_pkg::CTRL_SRC_LSB +: 2] = s_r.src;
          s_nxt.rdata[cao_pkg::CTRL_TORQUE_BIT] = s_r.torque_mode;
          s_nxt.rdata[cao_pkg::CTRL_NV_BIT] = s_r.nv_en;
        end
        cao_pkg::ADDR_OFFSET:
          s_nxt.rdata[15:0] = s_r.offset;
        cao_pkg::ADDR_STATUS:
        begin
          s_nxt.rdata[cao_pkg::STAT_DONE_BIT] = s_r.done;
          s_nxt.rdata[cao_pkg::STAT_ARMED_BIT] = (s_r.phase == cao_pkg::PH_ARMED);
          s_nxt.rdata[cao_pkg::STAT_ACTIVE_BIT] = s_r.drv.adj_active;
          s_nxt.rdata[cao_pkg::STAT_PHASE_LSB +: 3] = 3'(s_r.phase);
        end
        cao_pkg::ADDR_ANGLE:
        begin
          s_nxt.rdata[15:0] = s_r.drv.fb_angle;
          s_nxt.rdata[cao_pkg::ANGLE_PHASE_LSB +: 16] = s_r.drv.phase_angle;
        end
        cao_pkg::ADDR_GAIN:
          s_nxt.rdata[15:0] = s_r.gain;
        cao_pkg::ADDR_TMAX:
          s_nxt.rdata[15:0] = s_r.tmax;
        default:
          s_nxt.rdata = 32'h00000000;
      endcase
    end

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    if (wr)
    begin
      unique case (paddr)
        cao_pkg::ADDR_CTRL:
        begin
          s_nxt.src = pwdata[cao_pkg::CTRL_SRC_LSB +: 2];
          s_nxt.torque_mode = pwdata[cao_pkg::CTRL_TORQUE_BIT];
          s_nxt.nv_en = pwdata[cao_pkg::CTRL_NV_BIT];
          s_nxt.drv.param_save = pwdata[cao_pkg::CTRL_SAVE_BIT];
          if (pwdata[cao_pkg::CTRL_START_BIT] && s_r.phase == cao_pkg::PH_IDLE)
          begin
            s_nxt.phase = cao_pkg::PH_ARMED;
            s_nxt.done = 1'b1;
          end
        end
        cao_pkg::ADDR_OFFSET:
          s_nxt.offset = pwdata[15:0];
        cao_pkg::ADDR_GAIN:
          s_nxt.gain = pwdata[15:0];
        cao_pkg::ADDR_TMAX:
          s_nxt.tmax = pwdata[15:0];
        default:
          s_nxt.ms = s_r.ms;
      endcase
    end

    // ----------------------------------------------------------------
    // Millisecond divider
    // ----------------------------------------------------------------
    s_nxt.div = tick ? 32'h00000000 : s_r.div + 32'h00000001;

    // ----------------------------------------------------------------
    // Adjustment sequencer
    // ----------------------------------------------------------------
    unique case (s_r.phase)
      cao_pkg::PH_IDLE:
        s_nxt.ms = 16'h0000;
      cao_pkg::PH_ARMED:
      begin
        if (fb.drive_enable && s_r.torque_mode)
        begin
          s_nxt.phase = cao_pkg::PH_LOOSEN;
          s_nxt.ms = 16'h0000;
          s_nxt.div = 32'h00000000;
        end
      end
      cao_pkg::PH_LOOSEN:
      begin
        if (!fb.drive_enable)
          s_nxt.phase = cao_pkg::PH_IDLE;
        else if (tick)
        begin
          if (span_end(s_r.ms, LOOSEN_MS))
          begin
            s_nxt.phase = cao_pkg::PH_ALIGN;
            s_nxt.ms = 16'h0000;
          end
          else
            s_nxt.ms = ms_step(s_r.ms);
        end
      end
      cao_pkg::PH_ALIGN:
      begin
        if (!fb.drive_enable)
          s_nxt.phase = cao_pkg::PH_IDLE;
        else if (tick)
        begin
          if (span_end(s_r.ms, ALIGN_MS))
          begin
            s_nxt.phase = cao_pkg::PH_IDLE;
            s_nxt.offset = cao_pkg::ALIGN_ANGLE - sel_angle;
            s_nxt.done = 1'b0;
            s_nxt.drv.nv_save = s_r.nv_en;
            s_nxt.ms = 16'h0000;
          end
          else
            s_nxt.ms = ms_step(s_r.ms);
        end
      end
      default:
        s_nxt.phase = cao_pkg::PH_IDLE;
    endcase

    // ----------------------------------------------------------------
    // Registered outputs
    // ----------------------------------------------------------------
    s_nxt.drv.adj_active = (s_nxt.phase == cao_pkg::PH_LOOSEN) ||
                           (s_nxt.phase == cao_pkg::PH_ALIGN);
    s_nxt.drv.fb_angle = sel_angle;
    if (s_nxt.phase == cao_pkg::PH_ALIGN)
      s_nxt.drv.phase_angle = cao_pkg::ALIGN_ANGLE;
    else
      s_nxt.drv.phase_angle = sel_angle + s_nxt.offset;
    unique case (s_nxt.phase)
      cao_pkg::PH_LOOSEN:
        s_nxt.drv.torque_cmd = frac_torque(s_nxt.tmax, 3);
      cao_pkg::PH_ALIGN:
        s_nxt.drv.torque_cmd = frac_torque(s_nxt.tmax, 2);
      default:
        s_nxt.drv.torque_cmd = 16'h0000;
    endcase
    s_nxt.drv.gain_eff = s_nxt.drv.adj_active ? (s_nxt.gain >> 1) : s_nxt.gain;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (srst)
      s_r <= cao_pkg::RST_STATE;
    else
      s_r <= s_nxt;
  end

endmodule

// ---- cao_pkg.sv ----
// Constants, types and register map of the commutation angle block
package cao_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_OFFSET = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_ANGLE = 8'h0c;
  localparam logic [7:0] ADDR_GAIN = 8'h10;
  localparam logic [7:0] ADDR_TMAX = 8'h14;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_TORQUE_BIT = 2;
  localparam int CTRL_START_BIT = 3;
  localparam int CTRL_NV_BIT = 4;
  localparam int CTRL_SAVE_BIT = 5;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_ACTIVE_BIT = 2;
  localparam int STAT_PHASE_LSB = 4;
  localparam int ANGLE_PHASE_LSB = 16;

  // ----------------------------------------------------------------
  // Feedback source codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_ZERO = 2'h0;
  localparam logic [1:0] SRC_RESOLVER = 2'h1;
  localparam logic [1:0] SRC_ENCODER = 2'h2;

  // ----------------------------------------------------------------
  // Values after reset, and the alignment angle
  // ----------------------------------------------------------------
  localparam logic [1:0] RST_SRC = 2'h0;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_GAIN = 16'h4000;
  localparam logic [15:0] RST_TMAX = 16'h7fff;
  localparam logic [15:0] ALIGN_ANGLE = 16'h4000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000000 * TICK_US;
  localparam int unsigned LOOSEN_MS = 1000;
  localparam int unsigned ALIGN_MS = 2000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {PH_IDLE, PH_ARMED, PH_LOOSEN, PH_ALIGN} cao_phase_e;

  typedef struct packed {
    logic [15:0] resolver_pos;
    logic [15:0] encoder_pos;
    logic drive_enable;
  } cao_fb_s;

  typedef struct packed {
    logic [15:0] fb_angle;
    logic [15:0] phase_angle;
    logic [15:0] torque_cmd;
    logic [15:0] gain_eff;
    logic adj_active;
    logic nv_save;
    logic param_save;
  } cao_drv_s;

  typedef struct packed {
    cao_phase_e phase;
    logic [1:0] src;
    logic torque_mode;
    logic nv_en;
    logic done;
    logic [15:0] offset;
    logic [15:0] gain;
    logic [15:0] tmax;
    logic [31:0] div;
    logic [15:0] ms;
    logic [31:0] rdata;
    cao_drv_s drv;
  } cao_state_s;

  localparam cao_state_s RST_STATE = '{
    phase: PH_IDLE,
    src: RST_SRC,
    torque_mode: 1'b0,
    nv_en: 1'b0,
    done: 1'b0,
    offset: RST_OFFSET,
    gain: RST_GAIN,
    tmax: RST_TMAX,
    div: 32'h00000000,
    ms: 16'h0000,
    rdata: 32'h00000000,
    drv: '0
  };

endpackage

// ---- cao_asserts.sv ----
// Port checks for the commutation angle block
`timescale 1ns/1ns
module cao_asserts #(
  parameter logic [31:0] TICK_CYCLES = 32'h4,
  parameter logic [15:0] LOOSEN_MS = 16'h3,
  parameter logic [15:0] ALIGN_MS = 16'h5
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cao_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cao_pkg::cao_fb_s fb,
  input wire cao_pkg::cao_drv_s drv
);
  localparam int LC = int'(LOOSEN_MS) * int'(TICK_CYCLES);
  logic wr, wc, wo, wg, wt, nv_r, stale_r;
  logic [1:0] src_r;
  logic [15:0] off_r, gain_r, tmax_r;
  int cnt_r;
  // ----------------------------------------------------------------
  // Shadow registers
  // ----------------------------------------------------------------
  assign wr = psel && penable && pwrite && !pslverr;
  assign wc = wr && paddr == cao_pkg::ADDR_CTRL;
  assign wo = wr && paddr == cao_pkg::ADDR_OFFSET;
  assign wg = wr && paddr == cao_pkg::ADDR_GAIN;
  assign wt = wr && paddr == cao_pkg::ADDR_TMAX;
  always_ff @(posedge mclk) src_r <= srst ? 2'h0 : (wc ? pwdata[1:0] : src_r);
  always_ff @(posedge mclk) nv_r <= srst ? 1'b0 : (wc ? pwdata[4] : nv_r);
  always_ff @(posedge mclk) off_r <= srst ? 16'h0 : (wo ? pwdata[15:0] : off_r);
  always_ff @(posedge mclk) gain_r <= srst ? 16'h4000 : (wg ? pwdata[15:0] : gain_r);
  always_ff @(posedge mclk) tmax_r <= srst ? 16'h7fff : (wt ? pwdata[15:0] : tmax_r);
  always_ff @(posedge mclk) stale_r <= !srst && (drv.adj_active || (stale_r && !wo));
  always_ff @(posedge mclk) cnt_r <= srst || !drv.adj_active ? 0 : cnt_r + 1;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  a_zero_hold: assert property ($past(src_r) inside {2'h0, 2'h3} |-> drv.fb_angle == 16'h0)
    else $error("zero source angle wrong");
  a_res_pick: assert property ($past(src_r) == 2'h1 |-> drv.fb_angle == $past(fb.resolver_pos))
    else $error("resolver angle wrong");
  a_enc_pick: assert property ($past(src_r) == 2'h2 |-> drv.fb_angle == $past(fb.encoder_pos))
    else $error("encoder angle wrong");
  a_offset_add: assert property (!$past(stale_r) |-> drv.phase_angle == 16'(drv.fb_angle + off_r))
    else $error("phase angle wrong");
  a_gain_half: assert property (!$past(srst) && $stable(gain_r) |->
    drv.gain_eff == (drv.adj_active ? gain_r >> 1 : gain_r))
    else $error("loop gain wrong");
  a_loosen_torque: assert property (drv.adj_active && cnt_r < LC - 1 |-> drv.torque_cmd == tmax_r >> 3)
    else $error("loosen torque wrong");
  a_align_torque: assert property (drv.adj_active && cnt_r > LC |->
    drv.torque_cmd == tmax_r >> 2 && drv.phase_angle == cao_pkg::ALIGN_ANGLE)
    else $error("align torque wrong");
  a_start_enable: assert property ($rose(drv.adj_active) |-> $past(fb.drive_enable))
    else $error("start without enable");
  a_abort_drop: assert property (drv.adj_active && !fb.drive_enable |-> ##[1:2] !drv.adj_active)
    else $error("no abort");
  a_save_pulse: assert property (wc && pwdata[5] |=> drv.param_save)
    else $error("no save pulse");
  a_nv_pulse: assert property (drv.nv_save |-> nv_r && $fell(drv.adj_active))
    else $error("stray storage pulse");
  c_done: cover property ($fell(drv.adj_active));
  c_enc: cover property ($past(src_r) == 2'h2 && drv.fb_angle != 16'h0);
  c_nv: cover property (drv.nv_save);
endmodule

// ---- cao_motor.sv ----
// Behavioural rotor with resolver and encoder pickups
`timescale 1ns/1ns
module cao_motor #(
  parameter logic [15:0] SKEW = 16'h0777,
  parameter logic [15:0] MOUNT = 16'h1234
) (
  input wire logic mclk,
  input wire cao_pkg::cao_drv_s drv,
  input wire logic ld,
  input wire logic [15:0] ld_pos,
  output logic [15:0] res_pos,
  output logic [15:0] enc_pos
);
  logic [15:0] rot_r;
  // Free rotor follows the driven field
  always_ff @(posedge mclk)
    rot_r <= ld ? ld_pos : (drv.torque_cmd != 16'h0 ? drv.phase_angle + SKEW : rot_r);
  assign res_pos = rot_r;
  assign enc_pos = rot_r + MOUNT;
endmodule

// ---- commutation_angle_offset_adjust_test.sv ----
// Self-checking bench for the commutation angle block
`timescale 1ns/1ns
module commutation_angle_offset_adjust_test;
  localparam int LC = 12;
  localparam int AC = 20;
  logic mclk, srst, psel, penable, pwrite, pready, pslverr, ld, en, se;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] ld_pos, res, enc, e;
  cao_pkg::cao_fb_s fb;
  cao_pkg::cao_drv_s drv;
  int err_count, checked, n, nv_cnt, ps_cnt;
  assign fb = {res, enc, en};
  cao_angle #(.TICK_CYCLES(32'h4), .LOOSEN_MS(16'h3), .ALIGN_MS(16'h5)) dut_u (.mclk, .srst,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .fb, .drv);
  cao_motor mot_u (.mclk, .drv, .ld, .ld_pos, .res_pos(res), .enc_pos(enc));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_act(input logic v);
    while (drv.adj_active !== v && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h4000);
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h7fff);
    apb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 8'h04, 32'h1000);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h1000);
    check(se, 1'b0);
    apb(1'b0, 8'h18, 32'h0);
    check(se, 1'b1);
    check(rd, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_src;
    @(posedge mclk);
    ld <= 1'b1;
    ld_pos <= 16'h2345;
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, 8'h00, s);
      repeat (2) @(posedge mclk);
      apb(1'b0, 8'h0c, 32'h0);
      e = s == 1 ? 16'h2345 : (s == 2 ? 16'h3579 : 16'h0);
      check(rd[15:0], e);
      check(rd[31:16], e + 16'h1000);
    end
    $display("t_src done");
  endtask
  task automatic t_adj(input logic [1:0] s, input logic nv);
    @(posedge mclk);
    ld <= 1'b0;
    nv_cnt = 0;
    apb(1'b1, 8'h14, 32'h0800);
    apb(1'b1, 8'h00, {27'h0, nv, 2'b01, s});
    apb(1'b1, 8'h00, {27'h0, nv, 2'b11, s});
    apb(1'b0, 8'h08, 32'h0);
    check({rd[6:4], rd[2:0]}, 6'h0b);
    en <= 1'b1;
    n = 0;
    wait_act(1'b1);
    @(posedge mclk);
    check(drv.torque_cmd, 16'h0100);
    check(drv.gain_eff, 16'h2000);
    repeat (LC) @(posedge mclk);
    check({drv.torque_cmd, drv.phase_angle}, 32'h02004000);
    n = LC + 1;
    wait_act(1'b0);
    check(n >= LC + AC - 1 && n <= LC + AC + 1, 1'b1);
    en <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    check(rd[2:0], 3'h0);
    apb(1'b0, 8'h04, 32'h0);
    e = 16'h4000 - (s == 2'h1 ? 16'h4777 : 16'h59ab);
    check(rd, e);
    check(nv_cnt, nv);
    $display("t_adj done");
  endtask
  task automatic t_abort;
    apb(1'b1, 8'h00, 32'h0e);
    en <= 1'b1;
    n = 0;
    wait_act(1'b1);
    repeat (3) @(posedge mclk);
    en <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    check({rd[6:4], rd[2:0]}, 6'h01);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'he655);
    ps_cnt = 0;
    apb(1'b1, 8'h00, 32'h22);
    repeat (2) @(posedge mclk);
    check(ps_cnt, 1);
    $display("t_abort done");
  endtask
  // ----------------------------------------------------------------
  // Clock, monitor and main sequence
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    nv_cnt += drv.nv_save === 1'b1;
    ps_cnt += drv.param_save === 1'b1;
  end
  initial
  begin
    repeat (4000) @(posedge mclk);
    err_count++;
    conclude();
  end
  initial
  begin
    {srst, psel, penable, pwrite, en, ld} = 6'b100001;
    {paddr, pwdata, ld_pos} = '0;
    repeat (2) @(posedge mclk);
    srst <= 1'b0;
    t_regs();
    t_src();
    t_adj(2'h1, 1'b0);
    t_adj(2'h2, 1'b1);
    t_abort();
    conclude();
  end
endmodule
bind cao_angle cao_asserts #(.TICK_CYCLES(TICK_CYCLES), .LOOSEN_MS(LOOSEN_MS),
  .ALIGN_MS(ALIGN_MS)) chk_u (.mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .fb, .drv);
